// File: core/tws_slave.sv
`timescale 1ns/1ps
module tws_slave
  import tws_pkg::*;
(
  input  wire logic       clk,                // System clock, 100 MHz.
  input  wire logic       arst_n,             // Asynchronous reset, active low.
  input  wire logic       scl_in,             // SCL pin level.
  input  wire logic       sda_in,             // SDA pin level.
  output logic            sda_out,            // SDA drive value, always low.
  output logic            sda_oe,             // High while pulling SDA low.
  input  wire logic       address_select_pin, // Device select strap level.
  input  wire logic       wp_in,              // Write protect, high blocks.
  input  wire logic       nv_busy,            // Internal write cycle running.
  output logic            wr_valid,           // Write word available.
  input  wire logic       wr_ready,           // Write word taken.
  output logic [7:0]      wr_addr,            // Memory address of write.
  output logic [7:0]      wr_data,            // Data byte of write.
  output logic            wr_stop,            // Pulse on stop after a write.
  output logic            rd_req,             // Pulse asking for next byte.
  input  wire logic [7:0] rd_data,            // Byte to transmit.
  output logic            busy_out,           // Transfer in progress.
  output logic            wp_block            // Pulse when write was blocked.
);
  // *************************************************************
  // Line sampling and condition detection
  // *************************************************************
  logic scl_s;
  logic sda_s;
  logic wp_s;
  logic sel_s;

  // Both lines pass two flip-flops before any logic.
  tws_sync u_scl (.clk(clk), .arst_n(arst_n), .d_in(scl_in), .q_out(scl_s));
  tws_sync u_sda (.clk(clk), .arst_n(arst_n), .d_in(sda_in), .q_out(sda_s));
  tws_sync u_wp  (.clk(clk), .arst_n(arst_n), .d_in(wp_in),  .q_out(wp_s));
  tws_sync u_sel (.clk(clk), .arst_n(arst_n), .d_in(address_select_pin), .q_out(sel_s));

  typedef struct packed {
    tws_state_t  state;
    logic        scl_d;
    logic        sda_d;
    logic [3:0]  bitn;
    logic [7:0]  shreg;
    logic        rw;
    logic        ack_drv;
    logic        ack_pend;
    logic        tx_drv;
    logic        tx_bit;
    logic        nack;
    logic        wrote;
    logic [7:0]  addr;
    logic        rd_req;
    logic        wr_stop;
    logic        wp_block;
  } tws_core_t;

  tws_core_t st_reg;
  tws_core_t st_next;

  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;

  // SDA moving while SCL is high is a condition, not data.
  assign scl_rise = scl_s && !st_reg.scl_d;
  assign scl_fall = !scl_s && st_reg.scl_d;
  assign start_c  = scl_s && st_reg.scl_d && st_reg.sda_d && !sda_s;
  assign stop_c   = scl_s && st_reg.scl_d && !st_reg.sda_d && sda_s;

  // *************************************************************
  // Write buffer
  // *************************************************************
  logic        buf_push;
  logic        buf_ready;
  logic [15:0] buf_out;

  tws_buf #(.WIDTH(16)) u_buf (
    .clk     (clk),
    .arst_n  (arst_n),
    .s_valid (buf_push),
    .s_ready (buf_ready),
    .s_data  ({st_reg.addr, st_reg.shreg[6:0], sda_s}),
    .m_valid (wr_valid),
    .m_ready (wr_ready),
    .m_data  (buf_out)
  );
  assign wr_addr = buf_out[15:8];
  assign wr_data = buf_out[7:0];

  function automatic logic cmd_match(input logic [7:0] b, input logic sel);
    cmd_match = (b[7:2] == TWS_CTRL_CODE) && (b[1] == sel);
  endfunction

  // Rise count after the ninth pulse; the acknowledge slot ends on the next fall.
  localparam logic [3:0] TWS_ACK_DONE = TWS_ACK_SLOT + TWS_BIT_ONE;

  logic byte_done;
  assign byte_done = scl_rise && (st_reg.bitn == 4'(TWS_BYTE_BITS - 1));

  // Data byte is pushed at the eighth rising edge; protected writes are
  // dropped here so the position store never sees them.
  assign buf_push = byte_done && (st_reg.state == TWS_WDAT) && !wp_s;

  // *************************************************************
  // Protocol engine
  // *************************************************************
  always_comb
  begin
    st_next          = st_reg;
    st_next.scl_d    = scl_s;
    st_next.sda_d    = sda_s;
    st_next.rd_req   = 1'b0;
    st_next.wr_stop  = 1'b0;
    st_next.wp_block = 1'b0;

    if (scl_rise && st_reg.bitn < TWS_ACK_SLOT)
      st_next.shreg = {st_reg.shreg[6:0], sda_s};

    if (scl_rise && st_reg.bitn == TWS_ACK_SLOT && st_reg.tx_drv == 1'b0
        && st_reg.state == TWS_RDAT)
      st_next.nack = sda_s;

    if (byte_done)
    begin
      case (st_reg.state)
        TWS_CMD:
        begin
          // Acknowledge only a matching command.
          if (cmd_match({st_reg.shreg[6:0], sda_s}, sel_s))
          begin
            st_next.ack_pend = 1'b1;
            st_next.rw       = sda_s;
          end
          else
            st_next.state = TWS_IDLE;
        end
        TWS_ADDR:
        begin
          st_next.addr    = {st_reg.shreg[6:0], sda_s};
          st_next.ack_pend = 1'b1;
        end
        TWS_WDAT:
        begin
          if (wp_s)
            st_next.wp_block = 1'b1;
          else
            st_next.wrote = 1'b1;
          // Full buffer means no acknowledge unless write protect is high, so the master sees the loss.
          st_next.ack_pend = buf_ready || wp_s;
        end
        default:
        begin
          st_next.ack_pend = 1'b0;
        end
      endcase
    end

    if (scl_rise && st_reg.bitn != TWS_ACK_DONE)
      st_next.bitn = st_reg.bitn + TWS_BIT_ONE;

    // Acknowledge and transmit bits change on SCL falls, so SDA does not change under a high
    // clock; the busy check below can still drop a command acknowledge while SCL is high.
    if (scl_fall)
    begin
      if (st_reg.bitn == TWS_ACK_SLOT)
      begin
        // Eighth pulse over: the ninth slot belongs to the receiver.
        st_next.ack_drv  = st_reg.ack_pend;
        st_next.ack_pend = 1'b0;
        st_next.tx_drv   = 1'b0;
      end
      else if (st_reg.bitn == TWS_ACK_DONE)
      begin
        // Ninth pulse over: release SDA and set up the next byte.
        st_next.bitn    = TWS_BIT_ZERO;
        st_next.ack_drv = 1'b0;
        st_next.tx_drv  = 1'b0;
        case (st_reg.state)
          TWS_CMD:
            st_next.state = st_reg.rw ? TWS_RDAT : TWS_ADDR;
          TWS_ADDR:
            st_next.state = TWS_WDAT;
          TWS_RDAT:
            if (st_reg.nack)
              st_next.state = TWS_IDLE;
          default:
            st_next.state = st_reg.state;
        endcase
        if ((st_reg.state == TWS_CMD && st_reg.rw)
            || (st_reg.state == TWS_RDAT && !st_reg.nack))
        begin
          st_next.shreg  = rd_data;
          st_next.rd_req = 1'b1;
          st_next.tx_drv = 1'b1;
          st_next.tx_bit = rd_data[7];
        end
      end
      else if (st_reg.state == TWS_RDAT && st_reg.bitn != TWS_BIT_ZERO)
      begin
        // Transmit bits change only while SCL is low.
        st_next.tx_bit = st_reg.shreg[7];
      end
    end

    if (st_reg.state == TWS_RDAT && scl_rise && st_reg.bitn < TWS_ACK_SLOT)
      st_next.shreg = {st_reg.shreg[6:0], 1'b0};

    // Conditions override everything except the write-cycle busy check below.
    if (stop_c)
    begin
      st_next.state   = TWS_IDLE;
      st_next.ack_drv = 1'b0;
      st_next.tx_drv  = 1'b0;
      st_next.ack_pend = 1'b0;
      st_next.wr_stop = st_reg.wrote;
      st_next.wrote   = 1'b0;
    end
    else if (start_c)
    begin
      st_next.ack_drv = 1'b0;
      st_next.tx_drv  = 1'b0;
      st_next.bitn    = TWS_BIT_ZERO;
      st_next.nack    = 1'b0;
      st_next.ack_pend = 1'b0;
      st_next.state   = TWS_CMD;
    end

    // Inputs disabled while the internal write cycle runs, unless the transfer is in the address, write data or read data state.
    if (nv_busy && st_reg.state != TWS_RDAT && st_reg.state != TWS_WDAT
        && st_reg.state != TWS_ADDR)
    begin
      st_next.state   = TWS_BUSY;
      st_next.ack_drv = 1'b0;
      st_next.ack_pend = 1'b0;
    end
    else if (!nv_busy && st_reg.state == TWS_BUSY && !start_c)
      st_next.state = TWS_IDLE;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_reg       <= '0;
      st_reg.state <= TWS_IDLE;
      st_reg.scl_d <= 1'b1;
      st_reg.sda_d <= 1'b1;
    end
    else
      st_reg <= st_next;
  end

  // *************************************************************
  // Outputs
  // *************************************************************
  // SDA is open drain: only ever pulled low, else released.
  // Bit counting and SCL timing hold for 100 and 400 kHz alike.
  assign sda_out  = 1'b0;
  assign sda_oe   = st_reg.ack_drv || (st_reg.tx_drv && !st_reg.tx_bit);
  assign rd_req   = st_reg.rd_req;
  assign wr_stop  = st_reg.wr_stop;
  assign wp_block = st_reg.wp_block;
  assign busy_out = (st_reg.state != TWS_IDLE) && (st_reg.state != TWS_BUSY);

  // *************************************************************
  // Checks
  // *************************************************************
  property p_start_cmd;
    @(posedge clk) disable iff (!arst_n)
    start_c && !stop_c && !nv_busy |=> st_reg.state == TWS_CMD;
  endproperty
  a_start_cmd: assert property (p_start_cmd)
    else $error("Start did not enter command state.");

  property p_stop_idle;
    @(posedge clk) disable iff (!arst_n)
    stop_c && !nv_busy |=> st_reg.state == TWS_IDLE;
  endproperty
  a_stop_idle: assert property (p_stop_idle)
    else $error("Stop did not return to idle.");

  property p_release_idle;
    @(posedge clk) disable iff (!arst_n)
    st_reg.state == TWS_IDLE || st_reg.state == TWS_BUSY |-> !sda_oe;
  endproperty
  a_release_idle: assert property (p_release_idle)
    else $error("SDA driven while idle.");

  property p_nack_release;
    @(posedge clk) disable iff (!arst_n)
    scl_fall && st_reg.bitn == TWS_ACK_DONE && st_reg.state == TWS_RDAT && st_reg.nack
      && !start_c && !stop_c && !nv_busy |=> !sda_oe && st_reg.state == TWS_IDLE;
  endproperty
  a_nack_release: assert property (p_nack_release)
    else $error("SDA held after master not-acknowledge.");

  property p_ack_stable;
    @(posedge clk) disable iff (!arst_n)
    st_reg.ack_drv && scl_s && !start_c && !stop_c |=> st_reg.ack_drv || !st_reg.scl_d;
  endproperty
  a_ack_stable: assert property (p_ack_stable)
    else $error("Acknowledge released while SCL high.");

  property p_nomatch;
    @(posedge clk) disable iff (!arst_n)
    byte_done && st_reg.state == TWS_CMD && !start_c && !stop_c && !nv_busy
      && !cmd_match({st_reg.shreg[6:0], sda_s}, sel_s)
      |=> st_reg.state == TWS_IDLE && !st_reg.ack_pend;
  endproperty
  a_nomatch: assert property (p_nomatch)
    else $error("Mismatched command acknowledged.");

  property p_match_ack;
    @(posedge clk) disable iff (!arst_n)
    byte_done && st_reg.state == TWS_CMD && !start_c && !stop_c && !nv_busy
      && cmd_match({st_reg.shreg[6:0], sda_s}, sel_s)
      |=> st_reg.ack_pend;
  endproperty
  a_match_ack: assert property (p_match_ack)
    else $error("Matching command not acknowledged.");

  property p_ack_drive;
    @(posedge clk) disable iff (!arst_n)
    scl_fall && st_reg.bitn == TWS_ACK_SLOT && st_reg.ack_pend && !start_c && !stop_c
      && !nv_busy |=> sda_oe;
  endproperty
  a_ack_drive: assert property (p_ack_drive)
    else $error("Acknowledge not driven in ninth slot.");

  property p_wp_block;
    @(posedge clk) disable iff (!arst_n)
    wp_s && byte_done && st_reg.state == TWS_WDAT
      |-> !buf_push ##1 st_reg.wp_block;
  endproperty
  a_wp_block: assert property (p_wp_block)
    else $error("Write passed while protected.");

  property p_busy_ignore;
    @(posedge clk) disable iff (!arst_n)
    nv_busy && st_reg.state == TWS_BUSY |=> !st_reg.ack_drv && st_reg.state == TWS_BUSY;
  endproperty
  a_busy_ignore: assert property (p_busy_ignore)
    else $error("Bus answered during write cycle.");

  property p_tx_low_scl;
    @(posedge clk) disable iff (!arst_n)
    st_reg.state == TWS_RDAT && scl_s && st_reg.scl_d && !start_c && !stop_c
      |=> $stable(st_reg.tx_bit);
  endproperty
  a_tx_low_scl: assert property (p_tx_low_scl)
    else $error("Transmit bit changed while SCL high.");
endmodule // tws_slave

// File: pkg/tws_pkg.sv
// Contract
// - Idle bus is SDA and SCL high; transfers start only from idle.
// - SDA changes while SCL high are conditions, never data.
// - SDA falling while SCL high is a start condition.
// - SDA rising while SCL high is a stop condition.
// - One bit per SCL pulse; sampled high, changed only while low.
// - Bytes of eight bits MSB first, ninth slot is acknowledge.
// - No limit on bytes between start and stop.
// - Works at 100 kHz and 400 kHz SCL.
// - Acknowledge holds SDA low through the whole ninth SCL high.
// - Master not-acknowledge makes device release SDA for stop.
// - Receiver mode acknowledges command byte and every data byte; code gives no acknowledge for a data byte when the write buffer is full and write protect is low.
// - Repeated start ends one transfer and begins the next at once.
// - Command byte upper six bits compared with fixed control code.
// - Seventh command bit must equal the address select pin.
// - Command LSB one means read, zero means write.
// - Matching command byte is acknowledged on SDA.
// - Read command switches device to transmitter after acknowledge.
// - Position updates only while write protect pin is low.
// - Start and stop recognised at any time in both modes.
// - Mismatched command: no acknowledge, idle until next start.
// - Write: address byte then data bytes, each acknowledged; code does not acknowledge a data byte when the write buffer is full and write protect is low.
// - During internal write cycle ignore bus, no command acknowledge; code still serves a transfer in address, write data or read data state.
package tws_pkg;
  // Control code value is arbitrary, not a real part's code.
  localparam logic [5:0] TWS_CTRL_CODE = 6'h2A;
  localparam int         TWS_BYTE_BITS = 8;
  localparam logic [3:0] TWS_ACK_SLOT  = 4'h8;
  localparam logic [3:0] TWS_BIT_ZERO  = 4'h0;
  localparam logic [3:0] TWS_BIT_ONE   = 4'h1;
  localparam int         TWS_BUF_DEPTH = 2;

  typedef enum logic [5:0] {
    TWS_IDLE = 6'h01,
    TWS_CMD  = 6'h02,
    TWS_ADDR = 6'h04,
    TWS_WDAT = 6'h08,
    TWS_RDAT = 6'h10,
    TWS_BUSY = 6'h20
  } tws_state_t;
endpackage

// File: core/tws_sync.sv
`timescale 1ns/1ps
module tws_sync
  import tws_pkg::*;
(
  input  wire logic clk,    // System clock.
  input  wire logic arst_n, // Asynchronous reset.
  input  wire logic d_in,   // Asynchronous pin level.
  output logic      q_out   // Synchronised level.
);
  typedef struct packed {
    logic s1;
    logic s2;
  } tws_sync_t;

  tws_sync_t st_reg;
  tws_sync_t st_next;

  always_comb
  begin
    st_next    = st_reg;
    st_next.s1 = d_in;
    st_next.s2 = st_reg.s1;
  end

  // Bus lines idle high, so reset to high avoids a false start.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      st_reg <= '{s1: 1'b1, s2: 1'b1};
    else
      st_reg <= st_next;
  end

  assign q_out = st_reg.s2;
endmodule // tws_sync

// File: core/tws_buf.sv
`timescale 1ns/1ps
module tws_buf
  import tws_pkg::*;
#(
  parameter int WIDTH = 16
)
(
  input  wire logic             clk,     // System clock.
  input  wire logic             arst_n,  // Asynchronous reset.
  input  wire logic             s_valid, // Write request.
  output logic                  s_ready, // Space available.
  input  wire logic [WIDTH-1:0] s_data,  // Write data.
  output logic                  m_valid, // Data available.
  input  wire logic             m_ready, // Reader takes data.
  output logic      [WIDTH-1:0] m_data   // Oldest entry.
);
  typedef struct packed {
    logic [TWS_BUF_DEPTH-1:0][WIDTH-1:0] mem;
    logic                                rd;
    logic                                wr;
    logic [1:0]                          cnt;
  } tws_buf_t;

  tws_buf_t st_reg;
  tws_buf_t st_next;
  logic     push;
  logic     pop;

  assign s_ready = (st_reg.cnt != 2'(TWS_BUF_DEPTH));
  assign m_valid = (st_reg.cnt != 2'h0);
  assign m_data  = st_reg.mem[st_reg.rd];
  assign push    = s_valid && s_ready;
  assign pop     = m_valid && m_ready;

  always_comb
  begin
    st_next = st_reg;
    if (push)
    begin
      st_next.mem[st_reg.wr] = s_data;
      st_next.wr             = ~st_reg.wr;
    end
    if (pop)
      st_next.rd = ~st_reg.rd;
    st_next.cnt = st_reg.cnt + 2'(push) - 2'(pop);
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  property p_no_overflow;
    @(posedge clk) disable iff (!arst_n)
    s_valid && !s_ready && !m_ready |=> $stable(st_reg.mem);
  endproperty
  a_no_overflow: assert property (p_no_overflow)
    else $error("Buffer accepts while full.");
endmodule // tws_buf

// File: bench/tws_bus_master.sv
`timescale 1ns/1ps
module tws_bus_master
  import tws_pkg::*;
(
  input  wire logic clk,      // Pacing clock.
  input  wire logic sda_line, // Resolved SDA level.
  output logic      scl,      // Master SCL.
  output logic      sda_pull  // High while master pulls SDA low.
);
  // ****************************************
  // Bus master model, 80 ns SCL period
  // ****************************************
  // SCL stands high between frames; SDA rests on the pull-up when released.
  initial
  begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Data moves late in the low phase so a slave ack release never meets SCL rising.
  task automatic put_bit(input logic b);
    wait_clk(3);
    sda_pull <= ~b;
    wait_clk(1);
    scl <= 1'b1;
    wait_clk(4);
    scl <= 1'b0;
  endtask

  task automatic get_bit(output logic b);
    wait_clk(3);
    sda_pull <= 1'b0;
    wait_clk(1);
    scl <= 1'b1;
    wait_clk(3);
    b = sda_line;
    wait_clk(1);
    scl <= 1'b0;
  endtask

  // Also serves as a repeated start.
  task automatic start_cond();
    wait_clk(4);
    sda_pull <= 1'b0;
    wait_clk(4);
    scl <= 1'b1;
    wait_clk(4);
    sda_pull <= 1'b1;
    wait_clk(4);
    scl <= 1'b0;
  endtask

  task automatic stop_cond();
    wait_clk(3);
    sda_pull <= 1'b1;
    wait_clk(4);
    scl <= 1'b1;
    wait_clk(4);
    sda_pull <= 1'b0;
    wait_clk(4);
  endtask

  task automatic send_byte(input logic [7:0] v, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--)
      put_bit(v[i]);
    get_bit(a);
    ack = ~a;
  endtask

  task automatic recv_byte(output logic [7:0] v, input logic ack);
    for (int i = 7; i >= 0; i--)
      get_bit(v[i]);
    put_bit(~ack);
  endtask
endmodule // tws_bus_master

// File: bench/tws_slave_tb_top.sv
`timescale 1ns/1ps
module tws_slave_tb_top;
  import tws_pkg::*;
  logic       clk, arst_n, scl_in, m_pull, address_select_pin, wp_in, nv_busy;
  logic       wr_ready, sda_out, sda_oe, wr_valid, wr_stop, rd_req, busy_out, wp_block;
  logic [7:0] wr_addr, wr_data, rd_data;
  logic       sda_in;
  logic       ak;
  logic [7:0] rv;
  int         errors, n_checks, n_wpb, n_stop;

  // Open-drain wire with pull-up: any party enabling its driver wins low.
  assign sda_in = (sda_oe ? sda_out : 1'b1) & ~m_pull;

  tws_slave tws_slave_i (.clk(clk), .arst_n(arst_n), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .address_select_pin(address_select_pin),
    .wp_in(wp_in), .nv_busy(nv_busy), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_addr(wr_addr), .wr_data(wr_data), .wr_stop(wr_stop), .rd_req(rd_req),
    .rd_data(rd_data), .busy_out(busy_out), .wp_block(wp_block));
  tws_bus_master tws_bus_master_i (.clk(clk), .sda_line(sda_in), .scl(scl_in),
    .sda_pull(m_pull));

  // ****************************************
  // Clock, reset and monitors
  // ****************************************
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // The byte source steps by a fixed amount each time the slave takes a byte.
  always @(posedge clk)
  begin
    if (rd_req === 1'b1) rd_data <= rd_data + 8'h11;
    if (wp_block === 1'b1) n_wpb++;
    if (wr_stop === 1'b1) n_stop++;
  end

  // ****************************************
  // Checking helpers
  // ****************************************
  task automatic tally_and_finish();
    $display("errors=%0d n_checks=%0d", errors, n_checks);
    if (errors == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk1(input logic got, input logic exp);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t bit got %b exp %b", $time, got, exp);
    end
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t byte got %h exp %h", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] cmd(input logic sel, input logic rd);
    return {TWS_CTRL_CODE, sel, rd};
  endfunction

  task automatic xfer(input logic [7:0] v, input logic exp_ack);
    tws_bus_master_i.send_byte(v, ak);
    chk1(ak, exp_ack);
  endtask

  task automatic pop(input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    while (wr_valid !== 1'b1 && n < 50)
    begin
      @(posedge clk);
      n++;
    end
    chk8(wr_addr, a);
    chk8(wr_data, d);
    wr_ready <= 1'b1;
    @(posedge clk);
    wr_ready <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_idle();
    chk1(sda_oe, 1'b0);
    chk1(busy_out, 1'b0);
  endtask

  task automatic t_write_full();
    int s0;
    s0 = n_stop;
    tws_bus_master_i.start_cond();
    xfer(cmd(1'b0, 1'b0), 1'b1);
    chk1(busy_out, 1'b1);
    xfer(8'h5A, 1'b1);
    xfer(8'hC3, 1'b1);
    xfer(8'h3C, 1'b1);
    xfer(8'h99, 1'b0);
    tws_bus_master_i.stop_cond();
    pop(8'h5A, 8'hC3);
    pop(8'h5A, 8'h3C);
    chk1(wr_valid, 1'b0);
    chk1(n_stop == s0 + 1, 1'b1);
  endtask

  task automatic t_refuse();
    logic [7:0] bad [3];
    bad[0] = cmd(1'b1, 1'b0);
    bad[1] = {TWS_CTRL_CODE ^ 6'h01, 2'b00};
    bad[2] = {TWS_CTRL_CODE ^ 6'h20, 2'b01};
    for (int i = 0; i < 3; i++)
    begin
      tws_bus_master_i.start_cond();
      xfer(bad[i], 1'b0);
      xfer(8'h00, 1'b0);
      tws_bus_master_i.stop_cond();
    end
    nv_busy <= 1'b1;
    tws_bus_master_i.start_cond();
    xfer(cmd(1'b0, 1'b0), 1'b0);
    tws_bus_master_i.stop_cond();
    nv_busy <= 1'b0;
    address_select_pin <= 1'b1;
    tws_bus_master_i.start_cond();
    xfer(cmd(1'b1, 1'b0), 1'b1);
    tws_bus_master_i.stop_cond();
    address_select_pin <= 1'b0;
  endtask

  task automatic t_protect();
    int w0;
    w0 = n_wpb;
    wp_in <= 1'b1;
    tws_bus_master_i.start_cond();
    xfer(cmd(1'b0, 1'b0), 1'b1);
    xfer(8'h20, 1'b1);
    xfer(8'h77, 1'b1);
    tws_bus_master_i.stop_cond();
    repeat (10) @(posedge clk);
    chk1(wr_valid, 1'b0);
    chk1(n_wpb == w0 + 1, 1'b1);
    wp_in <= 1'b0;
  endtask

  // The address byte alone writes nothing, so no word and no stop pulse appear.
  task automatic t_read();
    int s0;
    s0 = n_stop;
    tws_bus_master_i.start_cond();
    xfer(cmd(1'b0, 1'b0), 1'b1);
    xfer(8'h10, 1'b1);
    tws_bus_master_i.start_cond();
    xfer(cmd(1'b0, 1'b1), 1'b1);
    chk1(busy_out, 1'b1);
    tws_bus_master_i.recv_byte(rv, 1'b1);
    chk8(rv, 8'hA5);
    tws_bus_master_i.recv_byte(rv, 1'b0);
    chk8(rv, 8'hB6);
    repeat (6) @(posedge clk);
    chk1(sda_oe, 1'b0);
    tws_bus_master_i.stop_cond();
    repeat (6) @(posedge clk);
    chk1(busy_out, 1'b0);
    chk1(wr_valid, 1'b0);
    chk1(n_stop == s0, 1'b1);
  endtask

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial
  begin
    errors = 0;
    n_checks = 0;
    n_wpb = 0;
    n_stop = 0;
    arst_n = 1'b0;
    address_select_pin = 1'b0;
    wp_in = 1'b0;
    nv_busy = 1'b0;
    wr_ready = 1'b0;
    rd_data = 8'hA5;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    repeat (5) @(posedge clk);
    t_idle();
    t_write_full();
    t_refuse();
    t_protect();
    t_read();
    tally_and_finish();
  end

  // A full run needs about 1800 cycles; the limit leaves ample margin.
  initial
  begin
    #300000;
    errors++;
    $display("[ERR] %0t watchdog expired", $time);
    tally_and_finish();
  end
endmodule // tws_slave_tb_top
